// ### hdl/sms_defs.svh
`ifndef SMS_DEFS_SVH
`define SMS_DEFS_SVH

// byte width and receive buffer depth
`define SMS_DATA_W 8
`define SMS_FIFO_DEPTH 16

// sixteen clock edges make one byte
`define SMS_EDGE_LAST 4'hf

// highest usable rate code, and the half period of the fastest rate
`define SMS_RATE_MAX 3'h5
`define SMS_HALF_MIN 7'h02

// pin synchroniser layout: ss_n, sck, mosi, miso
`define SMS_PIN_W 4
`define SMS_PIN_RST 4'h8

// reset values of shifter, edge count and divider state
`define SMS_BYTE_RST 8'h00
`define SMS_EDGE_RST 4'h0
`define SMS_DIV_RST 7'h00

`endif

// ### hdl/sms_pkg.sv
package sms_pkg;

   // master side sequencer
   typedef enum logic {
      SMS_IDLE,
      SMS_XFER
   } sms_state_e;

endpackage : sms_pkg

// ### hdl/sms_sync.sv
`timescale 1ns/1ps
module sms_sync #(
   parameter int W = 4,
   parameter logic [W-1:0] RST = '0
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic [W-1:0] din,
   output logic [W-1:0] dout
);

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         logic s1_q, s2_q, s3_q, out_q;
         // stage one feeds stage two only; output follows once two and three agree
         always_ff @(posedge clk) begin
            if (srst) begin
               s1_q <= RST[i];
               s2_q <= RST[i];
               s3_q <= RST[i];
               out_q <= RST[i];
            end else begin
               s1_q <= din[i];
               s2_q <= s1_q;
               s3_q <= s2_q;
               if (s2_q == s3_q) begin
                  out_q <= s3_q;
               end
            end
         end
         assign dout[i] = out_q;
      end
   endgenerate

endmodule : sms_sync

// ### hdl/sms_fifo.sv
`timescale 1ns/1ps
module sms_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);
   localparam logic [AW:0] FULL = (AW + 1)'(DEPTH);

   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wr_q, rd_q;
   logic [AW:0] cnt_q;
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   assign in_ready = (cnt_q != FULL);
   assign out_valid = (cnt_q != '0);
   assign out_data = mem[rd_q];

   // storage has no reset; only pointers and count need a defined value
   always_ff @(posedge clk) begin
      if (push) begin
         mem[wr_q] <= in_data;
      end
   end

   // pointers wrap at a power-of-two depth
   always_ff @(posedge clk) begin
      if (srst) begin
         wr_q <= '0;
         rd_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop) rd_q <= rd_q + 1'b1;
         case ({push, pop})
            2'b10: cnt_q <= cnt_q + 1'b1;
            2'b01: cnt_q <= cnt_q - 1'b1;
            default: cnt_q <= cnt_q;
         endcase
      end
   end

endmodule : sms_fifo

// ### hdl/sms_top.sv
`timescale 1ns/1ps
`include "sms_defs.svh"
// Function
// - bytes shift most significant bit first, both directions
// - master starts each transfer and drives sck; slave answers on miso
// - soft select mode ignores the ss pin and uses the soft level
// - master select and enable stay set only while internal select high
// - slave phase 0 needs select high between bytes, else write collides
// - master sck uses one of six rates, fastest is clock over four
// - slave accepts an external serial clock
// - master data write loads shifter and starts sending on mosi
// - transfer end sets done flag, interrupt if enabled and unmasked
// - master clears done by status access then data read
// - data writes ignored while done set until status access
// - slave data write loads shifter, clocked out on miso by master sck
// - slave clears done by status access then data read or write
// - polarity and phase pick capture edge; phase 0 first, 1 second
// - master with select low sets mode fault, drops enable and master
// - write during transfer is dropped, sets collision flag, no interrupt
module sms_top (
   input wire logic clk,
   input wire logic srst,
   input wire logic [2:0] clock_rate_select,
   input wire logic clk_polarity,
   input wire logic clk_phase,
   input wire logic soft_select_mode,
   input wire logic soft_select_level,
   input wire logic transfer_irq_enable,
   input wire logic cpu_condition_code_mask,
   input wire logic serial_control_reg_wr,
   input wire logic ctrl_master_select,
   input wire logic ctrl_port_enable,
   input wire logic serial_ctrl_status_reg_acc,
   input wire logic serial_data_reg_wr,
   input wire logic [7:0] serial_data_reg_wdata,
   input wire logic serial_data_reg_rd,
   output logic [7:0] serial_data_reg_rdata,
   output logic rx_valid,
   output logic rx_full,
   output logic master_select,
   output logic port_enable,
   output logic transfer_done_flag,
   output logic mode_fault_flag,
   output logic write_collision_flag,
   output logic overrun_flag,
   output logic busy,
   output logic transfer_irq,
   input wire logic sck_in,
   output logic sck_out,
   output logic sck_oe,
   input wire logic mosi_in,
   output logic mosi_out,
   output logic mosi_oe,
   input wire logic miso_in,
   output logic miso_out,
   output logic miso_oe,
   input wire logic ss_n_in
);

   sms_pkg::sms_state_e state_q, state_d;
   logic master_select_q, en_q;
   logic done_q, seen_q, ovr_q, write_collision_flag_q, write_collision_flag_seen_q, mode_fault_flag_q, mode_fault_flag_seen_q;
   logic irq_q, dout_q, sck_tgl_q, sck_prev_q;
   logic [7:0] shreg_q;
   logic [3:0] edge_q;
   logic [6:0] div_q;
   logic [3:0] pin_s;
   logic rx_ready;
   logic [2:0] cap_dly_q, end_dly_q;
   logic [7:0] rx_q;
   localparam logic [3:0] PIN_RST = `SMS_PIN_RST;

   // pins pass the three-stage synchroniser before any use
   sms_sync #(
      .W(`SMS_PIN_W),
      .RST(`SMS_PIN_RST)
   ) u_sync (
      .clk(clk),
      .srst(srst),
      .din({ss_n_in, sck_in, mosi_in, miso_in}),
      .dout(pin_s)
   );

   wire ss_n_s = pin_s[3];
   wire sck_s = pin_s[2];
   wire mosi_s = pin_s[1];
   wire miso_s = pin_s[0];

   // internal select and mode decode
   wire ss_int = soft_select_mode ? soft_select_level : ss_n_s;
   wire is_master = master_select_q & en_q;
   wire is_slave = ~master_select_q & en_q;
   wire selected = is_slave & ~ss_int;
   wire mode_fault_flag_set = is_master & ~ss_int;

   // rate codes above the top one fall back to the slowest rate
   wire [2:0] rate = (clock_rate_select > `SMS_RATE_MAX) ? `SMS_RATE_MAX : clock_rate_select;
   wire [6:0] half = `SMS_HALF_MIN << rate;
   wire tick = is_master & (state_q == sms_pkg::SMS_XFER) & (div_q == half - 7'h01);

   // slave edges come from the filtered sck; a slow sck is assumed
   wire slv_edge = selected & (sck_s != sck_prev_q);
   wire sck_edge = is_master ? tick : slv_edge;
   wire sample = (edge_q[0] == clk_phase);
   wire last = sck_edge & (edge_q == `SMS_EDGE_LAST);
   wire din = is_master ? miso_s : mosi_s;
   wire [7:0] shifted = {shreg_q[6:0], din};

   // miso reaches us four clocks after our own sck edge, so the master reads
   // the bit for a sample edge three clocks later; without this the two
   // fastest rates would capture the previous bit
   wire cap_now = is_master ? cap_dly_q[2] : (sck_edge & sample);
   wire xfer_end = end_dly_q[2] | (last & ~is_master);
   wire [7:0] rx_in = {rx_q[6:0], din};
   wire [7:0] rx_byte = cap_now ? rx_in : rx_q;

   // phase 0 slave stays busy while selected so ss must rise between bytes
   wire slv_busy = selected & (~clk_phase | (edge_q != `SMS_EDGE_RST));
   wire xfer_busy = (state_q == sms_pkg::SMS_XFER) | slv_busy | (|end_dly_q);

   // write filtering: done-flag lockout, collisions, full receive buffer
   wire wr_block = done_q & ~seen_q;
   wire wr_collide = serial_data_reg_wr & xfer_busy;
   wire wr_ok = serial_data_reg_wr & ~xfer_busy & ~wr_block & en_q;
   wire load = wr_ok & (is_slave | rx_ready);
   wire start = load & is_master;

   // flag clear sequences
   wire data_acc = serial_data_reg_rd | serial_data_reg_wr;
   wire done_clr_ev = master_select_q ? serial_data_reg_rd : data_acc;
   wire done_clr = seen_q & done_clr_ev;
   wire done_d = xfer_end | (done_q & ~done_clr);
   wire ovr_set = xfer_end & done_q & ~done_clr;
   wire write_collision_flag_clr = write_collision_flag_seen_q & data_acc & ~wr_collide;
   wire mode_fault_flag_clr = mode_fault_flag_seen_q & serial_control_reg_wr;
   wire ctrl_ok = serial_control_reg_wr & (~mode_fault_flag_q | mode_fault_flag_seen_q);

   // master sequencer
   always_comb begin
      state_d = state_q;
      case (state_q)
         sms_pkg::SMS_IDLE: begin
            if (start) state_d = sms_pkg::SMS_XFER;
         end
         sms_pkg::SMS_XFER: begin
            if (~is_master | last) state_d = sms_pkg::SMS_IDLE;
         end
         default: state_d = sms_pkg::SMS_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) state_q <= sms_pkg::SMS_IDLE;
      else state_q <= state_d;
   end

   // sck divider and toggle; toggle returns to zero after sixteen edges
   always_ff @(posedge clk) begin
      if (srst | start | tick | (state_q != sms_pkg::SMS_XFER)) div_q <= `SMS_DIV_RST;
      else div_q <= div_q + 7'h01;
   end

   always_ff @(posedge clk) begin
      if (srst | ~is_master) sck_tgl_q <= 1'b0;
      else if (tick) sck_tgl_q <= ~sck_tgl_q;
   end

   always_ff @(posedge clk) begin
      if (srst) sck_prev_q <= PIN_RST[2];
      else sck_prev_q <= sck_s;
   end

   // edge count restarts whenever no byte can be in progress
   always_ff @(posedge clk) begin
      if (srst | start | ~(is_master | selected)) edge_q <= `SMS_EDGE_RST;
      else if (sck_edge) edge_q <= edge_q + 4'h1;
   end

   // shifter: capture on sample edges, drive next bit on the other edges
   always_ff @(posedge clk) begin
      if (srst) begin
         shreg_q <= `SMS_BYTE_RST;
         dout_q <= 1'b0;
      end else if (load) begin
         shreg_q <= serial_data_reg_wdata;
         dout_q <= serial_data_reg_wdata[7];
      end else if (sck_edge & sample) begin
         shreg_q <= shifted;
      end else if (sck_edge) begin
         dout_q <= shreg_q[7];
      end
   end

   // delay lines align master capture and byte end with the lagging miso;
   // the port stays busy until the last bit has landed
   always_ff @(posedge clk) begin
      if (srst) begin
         cap_dly_q <= 3'h0;
         end_dly_q <= 3'h0;
      end else begin
         cap_dly_q <= {cap_dly_q[1:0], is_master & tick & sample};
         end_dly_q <= {end_dly_q[1:0], is_master & last};
      end
   end

   // receive shifter kept apart from the send shifter, which shifts on the undelayed sample edges
   always_ff @(posedge clk) begin
      if (srst) rx_q <= `SMS_BYTE_RST;
      else if (cap_now) rx_q <= rx_in;
   end

   // received bytes queue up; a slave byte is lost if the buffer is full
   sms_fifo #(
      .WIDTH(`SMS_DATA_W),
      .DEPTH(`SMS_FIFO_DEPTH)
   ) u_rx_fifo (
      .clk(clk),
      .srst(srst),
      .in_valid(xfer_end),
      .in_ready(rx_ready),
      .in_data(rx_byte),
      .out_valid(rx_valid),
      .out_ready(serial_data_reg_rd),
      .out_data(serial_data_reg_rdata)
   );

   // control bits: mode fault wins, writes refused while fault pending
   always_ff @(posedge clk) begin
      if (srst) begin
         master_select_q <= 1'b0;
         en_q <= 1'b0;
      end else if (mode_fault_flag_set) begin
         master_select_q <= 1'b0;
         en_q <= 1'b0;
      end else if (ctrl_ok) begin
         master_select_q <= ctrl_master_select;
         en_q <= ctrl_port_enable;
      end
   end

   // done flag and its status-access half of the clear sequence
   always_ff @(posedge clk) begin
      if (srst) begin
         done_q <= 1'b0;
         seen_q <= 1'b0;
      end else begin
         done_q <= done_d;
         seen_q <= done_d & ~xfer_end & (seen_q | (serial_ctrl_status_reg_acc & done_q));
      end
   end

   // error flags; a setting event always beats a clear in the same cycle
   always_ff @(posedge clk) begin
      if (srst) begin
         ovr_q <= 1'b0;
         write_collision_flag_q <= 1'b0;
         write_collision_flag_seen_q <= 1'b0;
         mode_fault_flag_q <= 1'b0;
         mode_fault_flag_seen_q <= 1'b0;
      end else begin
         ovr_q <= ovr_set | (ovr_q & ~serial_ctrl_status_reg_acc);
         write_collision_flag_q <= wr_collide | (write_collision_flag_q & ~write_collision_flag_clr);
         write_collision_flag_seen_q <= ~wr_collide & ~write_collision_flag_clr &
            (write_collision_flag_seen_q | (serial_ctrl_status_reg_acc & write_collision_flag_q));
         mode_fault_flag_q <= mode_fault_flag_set | (mode_fault_flag_q & ~mode_fault_flag_clr);
         mode_fault_flag_seen_q <= ~mode_fault_flag_set & ~mode_fault_flag_clr &
            (mode_fault_flag_seen_q | (serial_ctrl_status_reg_acc & mode_fault_flag_q));
      end
   end

   // collision has no interrupt of its own
   always_ff @(posedge clk) begin
      if (srst) irq_q <= 1'b0;
      else irq_q <= transfer_irq_enable & ~cpu_condition_code_mask &
         (done_q | mode_fault_flag_q | ovr_q);
   end

   // pin drive: master owns sck and mosi, selected slave owns miso
   assign sck_out = clk_polarity ^ sck_tgl_q;
   assign sck_oe = is_master;
   assign mosi_out = dout_q;
   assign mosi_oe = is_master;
   assign miso_out = dout_q;
   assign miso_oe = selected;

   // status outputs
   assign rx_full = ~rx_ready;
   assign master_select = master_select_q;
   assign port_enable = en_q;
   assign transfer_done_flag = done_q;
   assign mode_fault_flag = mode_fault_flag_q;
   assign write_collision_flag = write_collision_flag_q;
   assign overrun_flag = ovr_q;
   assign busy = xfer_busy;
   assign transfer_irq = irq_q;

endmodule : sms_top

// ### verif/sms_chk.sv
`timescale 1ns/1ps
`include "sms_defs.svh"
module sms_chk (
   input wire logic clk,
   input wire logic srst,
   input wire logic [2:0] clock_rate_select,
   input wire logic clk_polarity,
   input wire logic soft_select_mode,
   input wire logic soft_select_level,
   input wire logic transfer_irq_enable,
   input wire logic cpu_condition_code_mask,
   input wire logic serial_data_reg_wr,
   input wire logic [7:0] serial_data_reg_wdata,
   input wire logic master_select,
   input wire logic port_enable,
   input wire logic transfer_done_flag,
   input wire logic mode_fault_flag,
   input wire logic write_collision_flag,
   input wire logic overrun_flag,
   input wire logic busy,
   input wire logic transfer_irq,
   input wire logic sck_out,
   input wire logic mosi_out,
   input wire logic miso_oe
);
   logic [6:0] gap_q;
   logic [6:0] half;
   logic seen_q;
   logic sck_prev_q;
   logic wd7;
   logic irq_src;
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   // expected half period; codes above the top rate act as the top rate
   assign half = `SMS_HALF_MIN << ((clock_rate_select > `SMS_RATE_MAX) ? `SMS_RATE_MAX
                                   : clock_rate_select);
   assign wd7 = serial_data_reg_wdata[7];
   assign irq_src = transfer_irq_enable & ~cpu_condition_code_mask
                    & (transfer_done_flag | mode_fault_flag | overrun_flag);
   // cycles between sck changes; first change skipped since it starts from the write
   always_ff @(posedge clk) begin
      sck_prev_q <= sck_out;
      if (srst || !busy || sck_out != sck_prev_q) gap_q <= 7'h01;
      else gap_q <= gap_q + 7'h01;
      if (srst || !busy) seen_q <= 1'b0;
      else if (sck_out != sck_prev_q) seen_q <= 1'b1;
   end
   a_sck_rate: assert property (master_select && busy && seen_q && sck_out != sck_prev_q |->
      gap_q == half) else $error("sck half period wrong");
   a_sck_idle: assert property (master_select && !busy && $stable(clk_polarity) |->
      sck_out == clk_polarity) else $error("sck idle level wrong");
   a_mosi_msb: assert property ($rose(busy) && master_select |-> mosi_out == $past(wd7))
      else $error("first mosi bit not msb");
   a_done_end: assert property ($fell(busy) && master_select |-> transfer_done_flag)
      else $error("transfer end without done flag");
   a_irq_follow: assert property (transfer_irq == $past(irq_src))
      else $error("interrupt request mismatch");
   a_write_collision_flag_set: assert property (serial_data_reg_wr && busy && !transfer_done_flag |=>
      write_collision_flag) else $error("collision flag not set");
   a_fault_drop: assert property (master_select && soft_select_mode && !soft_select_level
      |-> ##[1:4] (mode_fault_flag && !master_select && !port_enable))
      else $error("mode fault not taken");
   a_miso_quiet: assert property (master_select && port_enable |-> !miso_oe)
      else $error("master drives miso");
endmodule : sms_chk
bind sms_top sms_chk chk (.*);

// ### verif/sms_spi_slave.sv
`timescale 1ns/1ps
module sms_spi_slave (
   input wire logic sck,
   input wire logic mosi,
   input wire logic sel_n,
   input wire logic cpol,
   input wire logic cpha,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte,
   output logic miso,
   output logic miso_en
);
   logic [7:0] sh_q;
   // load on select; phase 0 must show the first bit before any edge
   always @(negedge sel_n) begin
      sh_q = tx_byte;
      rx_byte = 8'h00;
      miso = tx_byte[7];
      if (!cpha) sh_q = {tx_byte[6:0], 1'b0};
   end
   // capture on the phase-selected edge, shift out on the other
   always @(sck) begin
      if (!sel_n) begin
         if ((sck != cpol) ^ cpha) rx_byte = {rx_byte[6:0], mosi};
         else begin
            miso = sh_q[7];
            sh_q = {sh_q[6:0], 1'b0};
         end
      end
   end
   assign miso_en = !sel_n; // released line is left to the bench
endmodule : sms_spi_slave

// ### verif/sms_top_test.sv
`timescale 1ns/1ps
module sms_top_test;
   logic clk = 0, srst = 1, tgl = 0, ss_n_in = 1, slv_sel_n = 1;
   logic [2:0] clock_rate_select = 3'h0;
   logic clk_polarity = 0, clk_phase = 0, soft_select_mode = 1, soft_select_level = 1;
   logic transfer_irq_enable = 1, cpu_condition_code_mask = 0, serial_data_reg_rd = 0;
   logic serial_control_reg_wr = 0, ctrl_master_select = 0, ctrl_port_enable = 0;
   logic serial_ctrl_status_reg_acc = 0, serial_data_reg_wr = 0, tb_sck = 0, tb_mosi = 0;
   logic [7:0] serial_data_reg_wdata = 8'h00, serial_data_reg_rdata, slv_tx = 8'h00, slv_rx;
   logic rx_valid, rx_full, master_select, port_enable, transfer_done_flag, mode_fault_flag;
   logic write_collision_flag, overrun_flag, busy, transfer_irq, tb_drv = 0, tb_tie = 0;
   logic sck_out, sck_oe, mosi_out, mosi_oe, miso_out, miso_oe, slv_miso, slv_en;
   int err_total = 0, checks_done = 0;
   // pin levels; undriven sck rests on the board pull, data lines toggle
   wire sck_w = sck_oe ? sck_out : (tb_drv ? tb_sck : clk_polarity);
   wire mosi_w = mosi_oe ? mosi_out : (tb_drv ? tb_mosi : tgl);
   wire miso_w = miso_oe ? miso_out : (slv_en ? slv_miso : (tb_tie ? mosi_w : tgl));
   sms_top uut (.*, .sck_in(sck_w), .mosi_in(mosi_w), .miso_in(miso_w));
   sms_spi_slave slv (.sck(sck_w), .mosi(mosi_w), .sel_n(slv_sel_n), .cpol(clk_polarity),
      .cpha(clk_phase), .tx_byte(slv_tx), .rx_byte(slv_rx), .miso(slv_miso), .miso_en(slv_en));
   initial forever #12.5 clk = ~clk;
   always @(posedge clk) tgl <= ~tgl;
   task automatic final_report;
      $display("checks %0d errors %0d", checks_done, err_total);
      if (err_total == 0 && checks_done > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : final_report
   task automatic check(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_total++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic pulse(ref logic s);
      @(negedge clk) s = 1;
      @(negedge clk) s = 0;
   endtask : pulse
   task automatic wait_done;
      int k;
      for (k = 0; k < 5000 && transfer_done_flag !== 1'b1; k++) @(negedge clk);
      if (k == 5000) begin
         err_total++;
         final_report;
      end
   endtask : wait_done
   // one byte each way as master; collision, blocked write and clearing
   task automatic t_master(input logic [2:0] r, input logic [7:0] d);
      ctrl_port_enable = 0;
      pulse(serial_control_reg_wr);
      clock_rate_select = r;
      clk_polarity = r[1];
      clk_phase = r[0];
      cpu_condition_code_mask = r[2];
      slv_tx = ~d;
      ctrl_master_select = 1;
      ctrl_port_enable = 1;
      pulse(serial_control_reg_wr);
      slv_sel_n = 0; // select only once sck rests at its new idle level
      serial_data_reg_wdata = d;
      pulse(serial_data_reg_wr);
      serial_data_reg_wdata = 8'hff;
      pulse(serial_data_reg_wr);
      check(write_collision_flag, 8'h01);
      wait_done;
      check(slv_rx, d);
      repeat (3) @(negedge clk);
      check(transfer_irq, {7'h00, !r[2]});
      pulse(serial_data_reg_wr);
      check(busy, 8'h00);
      check(serial_data_reg_rdata, ~d);
      pulse(serial_ctrl_status_reg_acc);
      pulse(serial_data_reg_rd);
      check({transfer_done_flag, write_collision_flag, rx_valid}, 8'h00);
      slv_sel_n = 1;
   endtask : t_master
   // soft select low while master, then the clearing sequence
   task automatic t_mode_fault_flag;
      soft_select_level = 0;
      repeat (6) @(negedge clk);
      check({mode_fault_flag, master_select, port_enable}, 8'h04);
      soft_select_level = 1;
      pulse(serial_control_reg_wr);
      check(master_select, 8'h00);
      pulse(serial_ctrl_status_reg_acc);
      pulse(serial_control_reg_wr);
      check({mode_fault_flag, master_select, port_enable}, 8'h03);
   endtask : t_mode_fault_flag
   // two bytes with done left set, miso tied to mosi as on a single data line
   task automatic t_ovr;
      int k;
      tb_tie = 1;
      serial_data_reg_wdata = 8'h3c;
      pulse(serial_data_reg_wr);
      wait_done;
      pulse(serial_ctrl_status_reg_acc);
      pulse(serial_data_reg_wr);
      check(busy, 8'h01);
      for (k = 0; k < 3000 && busy !== 1'b0; k++) @(negedge clk);
      if (k == 3000) begin
         err_total++;
         final_report;
      end
      check({overrun_flag, transfer_done_flag, rx_full}, 8'h06);
      check(serial_data_reg_rdata, 8'h3c);
      pulse(serial_ctrl_status_reg_acc);
      pulse(serial_data_reg_rd);
      check({overrun_flag, transfer_done_flag, rx_valid}, 8'h01);
      pulse(serial_data_reg_rd);
      check(rx_valid, 8'h00);
      tb_tie = 0;
   endtask : t_ovr
   // slave byte under a bench-made clock, phase 1, select held low
   task automatic t_slave(input logic [7:0] d);
      int b;
      logic [7:0] got;
      ctrl_master_select = 0;
      ctrl_port_enable = 0;
      pulse(serial_control_reg_wr);
      clk_polarity = 0;
      clk_phase = 1;
      repeat (4) @(negedge clk); // idle sck settles through the synchroniser first
      soft_select_level = 0;
      ctrl_port_enable = 1;
      pulse(serial_control_reg_wr);
      serial_data_reg_wdata = ~d;
      pulse(serial_data_reg_wr);
      tb_drv = 1;
      for (b = 7; b >= 0; b--) begin
         repeat (8) @(negedge clk);
         tb_sck = 1;
         tb_mosi = d[b];
         repeat (8) @(negedge clk);
         got = {got[6:0], miso_w};
         tb_sck = 0;
      end
      wait_done;
      check(got, ~d);
      check(serial_data_reg_rdata, d);
      pulse(serial_ctrl_status_reg_acc);
      pulse(serial_data_reg_wr);
      check(transfer_done_flag, 8'h00);
      tb_drv = 0;
      clk_phase = 0;
      pulse(serial_data_reg_wr);
      check(write_collision_flag, 8'h01);
      soft_select_level = 1;
      pulse(serial_ctrl_status_reg_acc);
      pulse(serial_data_reg_wr);
      check(write_collision_flag, 8'h00);
   endtask : t_slave
   // main sequence: every rate code and all four clock modes
   initial begin
      repeat (2) @(negedge clk);
      srst = 0;
      repeat (4) @(negedge clk);
      for (int i = 0; i < 8; i++) t_master(3'(i), 8'h96 ^ 8'(i * 37));
      t_mode_fault_flag;
      t_ovr;
      t_slave(8'hc5);
      final_report;
   end
endmodule : sms_top_test
